/* File: logic/lcw_pkg.sv */
// constants, field layouts and types of the low-frequency countdown watchdog
// assumes: one 32-bit apb slave window with 12 address bits
`default_nettype none

package lcw_pkg;

   // -------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFF_START = 12'h000;
   localparam logic [11:0] OFF_SUBSCRIBE = 12'h080;
   localparam logic [11:0] OFF_TIMEOUT = 12'h100;
   localparam logic [11:0] OFF_PUBLISH = 12'h180;
   localparam logic [11:0] OFF_IRQ_SET = 12'h304;
   localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
   localparam logic [11:0] OFF_RUN = 12'h400;
   localparam logic [11:0] OFF_REQ = 12'h404;
   localparam logic [11:0] OFF_RELOAD = 12'h504;
   localparam logic [11:0] OFF_SLOT_EN = 12'h508;
   localparam logic [11:0] OFF_PAUSE = 12'h50C;
   localparam logic [11:0] OFF_SLOT_BASE = 12'h600;
   localparam logic [11:0] OFF_SLOT_LAST = 12'h61C;

   // -------------------------------------------------------------
   // fields, reset values, key and timing
   // -------------------------------------------------------------
   localparam int unsigned N_SLOTS = 8;
   localparam int unsigned CHAN_W = 8;
   localparam int unsigned BIT_TRIGGER = 0;
   localparam int unsigned BIT_TIMEOUT = 0;
   localparam int unsigned BIT_RUN = 0;
   localparam int unsigned BIT_PAUSE_SLEEP = 0;
   localparam int unsigned BIT_PAUSE_HALT = 3;
   localparam int unsigned BIT_LINK_EN = 31;
   localparam logic [31:0] RELOAD_KEY = 32'h6E524635;
   localparam logic [31:0] RESET_RELOAD_VALUE = 32'hFFFFFFFF;
   localparam logic [7:0] RESET_SLOT_ENABLE = 8'h01;
   localparam int unsigned LF_CLOCK_HZ = 32768;
   localparam logic [1:0] RESET_DELAY_TICKS = 2'h2;
   localparam logic [31:0] READ_ZERO = 32'h00000000;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef struct packed {
      logic [31:0] reload_value;
      logic [7:0] slot_enable;
      logic pause_sleep;
      logic pause_halt;
   } lcw_cfg_type;

   typedef struct packed {
      logic en;
      logic [CHAN_W-1:0] channel_index;
   } lcw_link_type;

   typedef enum logic [1:0] {
      LCW_STOPPED,
      LCW_RUNNING,
      LCW_TIMED_OUT,
      LCW_RESETTING
   } lcw_state_type;

endpackage

`default_nettype wire

/* File: logic/lcw_watchdog.sv */
// countdown watchdog on the low-frequency clock, apb register slave
// assumes: low_freq_clock is a slow pin, sampled on sys_clk; other inputs
// come from logic on sys_clk; reset source and clock control are outside
`default_nettype none

// Function
// - watchdog starts only on start task, by register write or event
// - counter decrements and raises timeout when wrapping past zero
// - start task loads the counter from the reload value
// - one decrement per low-frequency cycle, period (reload+1)/32768
// - while running, request rc oscillator unless another source runs
// - eight reload-request slots for software
// - reload only after key written to every enabled slot
// - each slot enabled by its own bit of slot enable
// - by default counting continues in sleep and debug halt
// - pause in sleep and pause in halt separately configurable
// - every timeout raises a reset request to system reset logic unless off wake comes in the same cycle
// - with timeout interrupt enabled, reset delayed two lf cycles
// - once timeout is raised, reset follows; only an off wake in the same cycle cancels it
// - after start, writes to reload, slot enable and pause registers are ignored
// - after reset, or off wake while running, stopped and configuration writable
// - start subscription holds channel index and enable bit
// - run state reads 1 once started, 0 only while stopped
// - irq enable set register writes 1 to enable, reads state
module lcw_watchdog
   import lcw_pkg::*;
#(
   parameter int unsigned N_CHANNELS = 256
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_freq_clock,
   input wire logic other_lf_source_running,
   input wire logic cpu_sleeping,
   input wire logic debug_halted,
   input wire logic wake_from_off,
   input wire logic [N_CHANNELS-1:0] link_events,
   output logic [N_CHANNELS-1:0] link_publish,
   output logic rc_osc_request,
   output logic irq,
   output logic wdt_reset_req
);

   // -------------------------------------------------------------
   // elaboration check
   // -------------------------------------------------------------
   generate
      if (N_CHANNELS < 1 || N_CHANNELS > (1 << CHAN_W)) begin : g_bad
         $error("lcw_watchdog: N_CHANNELS out of range");
      end
   endgenerate

   // -------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------
   function automatic logic is_slot(input logic [ADDR_W-1:0] a);
      is_slot = (a >= OFF_SLOT_BASE) && (a <= OFF_SLOT_LAST) &&
                (a[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - OFF_SLOT_BASE;
      slot_of = d[4:2];
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_START, OFF_SUBSCRIBE, OFF_TIMEOUT, OFF_PUBLISH,
         OFF_IRQ_SET, OFF_IRQ_CLR, OFF_RUN, OFF_REQ,
         OFF_RELOAD, OFF_SLOT_EN, OFF_PAUSE: is_mapped = 1'b1;
         default: is_mapped = is_slot(a);
      endcase
   endfunction

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   lcw_state_type state_r;
   lcw_cfg_type cfg_r;
   lcw_link_type sub_r;
   lcw_link_type pub_r;
   logic [31:0] count_r;
   logic [N_SLOTS-1:0] requested_r;
   logic [1:0] delay_r;
   logic timeout_flag_r;
   logic irq_en_r;
   logic lf_s1_r;
   logic lf_s2_r;
   logic lf_s3_r;
   logic lf_level_r;
   logic lf_tick;
   logic wr_acc;
   logic start_cmd;
   logic locked;
   logic count_en;
   logic timeout_evt;
   logic all_requested;
   logic slot_key_wr;
   logic [2:0] wr_slot;
   logic [31:0] rd_mux;

   // -------------------------------------------------------------
   // low-frequency clock sampling
   // -------------------------------------------------------------
   // a level counts only once the second and third stages agree,
   // so a single glitch on the pin never ticks the counter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lf_s1_r <= 1'b0;
         lf_s2_r <= 1'b0;
         lf_s3_r <= 1'b0;
         lf_level_r <= 1'b0;
      end else if (ce) begin
         lf_s1_r <= low_freq_clock;
         lf_s2_r <= lf_s1_r;
         lf_s3_r <= lf_s2_r;
         if (lf_s2_r == lf_s3_r) begin
            lf_level_r <= lf_s3_r;
         end
      end
   end

   assign lf_tick = (lf_s2_r == lf_s3_r) && lf_s3_r && !lf_level_r;

   // -------------------------------------------------------------
   // control terms
   // -------------------------------------------------------------
   assign wr_acc = psel && penable && pwrite;
   assign locked = (state_r != LCW_STOPPED);
   assign start_cmd = (wr_acc && paddr == OFF_START &&
                       pwdata[BIT_TRIGGER]) ||
                      (sub_r.en &&
                       link_events[sub_r.channel_index]);
   assign count_en = !(cfg_r.pause_sleep && cpu_sleeping) &&
                     !(cfg_r.pause_halt && debug_halted);
   assign timeout_evt = (state_r == LCW_RUNNING) && lf_tick && count_en &&
                        (count_r == 32'h00000000);
   assign wr_slot = slot_of(paddr);
   assign slot_key_wr = wr_acc && is_slot(paddr) &&
                        (pwdata == RELOAD_KEY);
   assign all_requested = ((requested_r | ~cfg_r.slot_enable) ==
                           {N_SLOTS{1'b1}});

   // -------------------------------------------------------------
   // run state, counter and reset request
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= LCW_STOPPED;
         count_r <= RESET_RELOAD_VALUE;
         delay_r <= 2'h0;
         wdt_reset_req <= 1'b0;
      end else if (ce) begin
         case (state_r)
            LCW_STOPPED: begin
               if (start_cmd) begin
                  state_r <= LCW_RUNNING;
                  count_r <= cfg_r.reload_value;
               end
            end
            LCW_RUNNING: begin
               if (wake_from_off) begin
                  state_r <= LCW_STOPPED;
               end else if (timeout_evt) begin
                  count_r <= count_r - 32'h00000001;
                  state_r <= LCW_TIMED_OUT;
                  delay_r <= irq_en_r ? RESET_DELAY_TICKS : 2'h0;
               end else if (all_requested) begin
                  count_r <= cfg_r.reload_value;
               end else if (lf_tick && count_en) begin
                  count_r <= count_r - 32'h00000001;
               end
            end
            // no reload, start or wake leaves these two states
            LCW_TIMED_OUT: begin
               if (delay_r == 2'h0) begin
                  wdt_reset_req <= 1'b1;
                  state_r <= LCW_RESETTING;
               end else if (lf_tick) begin
                  delay_r <= delay_r - 2'h1;
               end
            end
            LCW_RESETTING: begin
               wdt_reset_req <= 1'b1;
            end
            default: begin
               state_r <= LCW_STOPPED;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // reload request slots
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         requested_r <= '0;
      end else if (ce) begin
         if (state_r != LCW_RUNNING || all_requested) begin
            requested_r <= '0;
         end else if (slot_key_wr && cfg_r.slot_enable[wr_slot]) begin
            requested_r[wr_slot] <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // configuration; reload, slot enable and pause locked while running
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_r.reload_value <= RESET_RELOAD_VALUE;
         cfg_r.slot_enable <= RESET_SLOT_ENABLE;
         cfg_r.pause_sleep <= 1'b0;
         cfg_r.pause_halt <= 1'b0;
         sub_r <= '0;
         pub_r <= '0;
      end else if (ce) begin
         if (wr_acc && !locked) begin
            case (paddr)
               OFF_RELOAD: cfg_r.reload_value <= pwdata;
               OFF_SLOT_EN: cfg_r.slot_enable <= pwdata[N_SLOTS-1:0];
               OFF_PAUSE: begin
                  cfg_r.pause_sleep <= pwdata[BIT_PAUSE_SLEEP];
                  cfg_r.pause_halt <= pwdata[BIT_PAUSE_HALT];
               end
               default: begin
               end
            endcase
         end
         if (wr_acc && paddr == OFF_SUBSCRIBE) begin
            sub_r.en <= pwdata[BIT_LINK_EN];
            sub_r.channel_index <= pwdata[CHAN_W-1:0];
         end
         if (wr_acc && paddr == OFF_PUBLISH) begin
            pub_r.en <= pwdata[BIT_LINK_EN];
            pub_r.channel_index <= pwdata[CHAN_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------
   // timeout flag, interrupt enable and side outputs
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timeout_flag_r <= 1'b0;
         irq_en_r <= 1'b0;
         irq <= 1'b0;
         rc_osc_request <= 1'b0;
         link_publish <= '0;
      end else if (ce) begin
         // set wins over a clear landing in the same cycle
         if (timeout_evt) begin
            timeout_flag_r <= 1'b1;
         end else if (wr_acc && paddr == OFF_TIMEOUT &&
                      !pwdata[BIT_TIMEOUT]) begin
            timeout_flag_r <= 1'b0;
         end
         if (wr_acc && paddr == OFF_IRQ_SET && pwdata[BIT_TIMEOUT]) begin
            irq_en_r <= 1'b1;
         end else if (wr_acc && paddr == OFF_IRQ_CLR &&
                      pwdata[BIT_TIMEOUT]) begin
            irq_en_r <= 1'b0;
         end
         irq <= timeout_flag_r && irq_en_r;
         rc_osc_request <= locked && !other_lf_source_running;
         link_publish <= '0;
         if (timeout_evt && pub_r.en) begin
            link_publish[pub_r.channel_index] <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // apb read path
   // -------------------------------------------------------------
   always_comb begin
      rd_mux = READ_ZERO;
      case (paddr)
         OFF_SUBSCRIBE: begin
            rd_mux[BIT_LINK_EN] = sub_r.en;
            rd_mux[CHAN_W-1:0] = sub_r.channel_index;
         end
         OFF_PUBLISH: begin
            rd_mux[BIT_LINK_EN] = pub_r.en;
            rd_mux[CHAN_W-1:0] = pub_r.channel_index;
         end
         OFF_TIMEOUT: rd_mux[BIT_TIMEOUT] = timeout_flag_r;
         OFF_IRQ_SET, OFF_IRQ_CLR: rd_mux[BIT_TIMEOUT] = irq_en_r;
         OFF_RUN: rd_mux[BIT_RUN] = locked;
         OFF_REQ: rd_mux[N_SLOTS-1:0] = cfg_r.slot_enable & ~requested_r;
         OFF_RELOAD: rd_mux = cfg_r.reload_value;
         OFF_SLOT_EN: rd_mux[N_SLOTS-1:0] = cfg_r.slot_enable;
         OFF_PAUSE: begin
            rd_mux[BIT_PAUSE_SLEEP] = cfg_r.pause_sleep;
            rd_mux[BIT_PAUSE_HALT] = cfg_r.pause_halt;
         end
         default: rd_mux = READ_ZERO;
      endcase
   end

   // data captured in the setup cycle so the access cycle needs no wait
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= READ_ZERO;
         pslverr <= 1'b0;
      end else if (ce) begin
         if (psel && !penable) begin
            prdata <= pwrite ? READ_ZERO : rd_mux;
            pslverr <= !is_mapped(paddr);
         end
      end
   end

   // a frozen clock enable holds the bus off rather than losing a write
   assign pready = ce;

endmodule

`default_nettype wire

/* File: sim/lcw_watchdog_asserts.sv */
// port assertions for the countdown watchdog, bound into lcw_watchdog
// assumes: ce held high, lf ticks at least 8 sys_clk apart
`default_nettype none
module lcw_watchdog_asserts
   import lcw_pkg::*;
#(
   parameter int unsigned N_CHANNELS = 256
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic other_lf_source_running,
   input wire logic wake_from_off,
   input wire logic [N_CHANNELS-1:0] link_events,
   input wire logic rc_osc_request,
   input wire logic irq,
   input wire logic wdt_reset_req
);
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   logic setup, start_hit, any_ev, clr_hit;
   assign setup = psel && !penable;
   assign start_hit = psel && penable && pwrite && paddr == OFF_START &&
      pwdata[BIT_TRIGGER];
   assign any_ev = |link_events;
   assign clr_hit = psel && penable && pwrite && paddr == OFF_TIMEOUT &&
      !pwdata[BIT_TIMEOUT];
   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   // rc request lags its cause by two edges
   start_cause_a: assert property ($rose(rc_osc_request) |->
      $past(start_hit, 2) || $past(any_ev, 2) ||
      $past(other_lf_source_running, 2)) else $error("rc rose unstarted");
   rc_gate_a: assert property (rc_osc_request |->
      !$past(other_lf_source_running)) else $error("rc with other source");
   rc_hold_a: assert property (rc_osc_request &&
      !other_lf_source_running && !$past(wake_from_off) |=> rc_osc_request)
      else $error("rc dropped while running");
   req_hold_a: assert property (wdt_reset_req |=> wdt_reset_req)
      else $error("reset request withdrawn");
   irq_reset_a: assert property ($rose(irq) |->
      ##[1:40] wdt_reset_req) else $error("no reset after timeout irq");
   irq_delay_a: assert property ($rose(irq) &&
      !$past(wdt_reset_req) |-> !wdt_reset_req [*5])
      else $error("reset not postponed");
   irq_clear_a: assert property (clr_hit |=> ##1 !irq)
      else $error("irq stayed after flag clear");
   slot_map_a: assert property (setup && paddr >= OFF_SLOT_BASE &&
      paddr <= OFF_SLOT_LAST && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("slot address refused");
   slot_end_a: assert property (setup &&
      paddr == OFF_SLOT_LAST + 12'h4 |=> pslverr)
      else $error("ninth slot accepted");
endmodule
bind lcw_watchdog lcw_watchdog_asserts #(.N_CHANNELS(N_CHANNELS)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .other_lf_source_running(other_lf_source_running),
   .wake_from_off(wake_from_off), .link_events(link_events),
   .rc_osc_request(rc_osc_request), .irq(irq),
   .wdt_reset_req(wdt_reset_req)
);
`default_nettype wire

/* File: sim/lcw_watchdog_tb.sv */
// self-checking bench for the countdown watchdog: table, then hand cases
// assumes: lcw_pkg, lcw_watchdog and the bound checker compiled first
`default_nettype none
module lcw_watchdog_tb
   import lcw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------------------------------------------
   // signals and helpers
   // -------------------------------------------------------------
   localparam int RLD = 7;
   localparam int LFP = 8; // short lf period keeps the run small
   typedef struct packed {
      logic w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic err;
   } lcw_row_type;
   logic sys_clk = 1'h0, rst = 1'h1, ce = 1'h1, psel = 1'h0;
   logic penable = 1'h0, pwrite = 1'h0, oth = 1'h0, slp = 1'h0;
   logic hlt = 1'h0, wake = 1'h0, pready, pslverr, er, rc, irq, req;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [255:0] ev = '0, pub;
   int n_pub = 0;
   logic [2:0] lf = 3'h0;
   int n_mismatch = 0, n_compared = 0, c;
   lcw_row_type rows [17] = '{
      '{1'h0, OFF_RELOAD, 32'h0, 32'hFFFFFFFF, 1'h0},
      '{1'h0, OFF_SLOT_EN, 32'h0, 32'h1, 1'h0},
      '{1'h0, OFF_PAUSE, 32'h0, 32'h0, 1'h0},
      '{1'h0, OFF_RUN, 32'h0, 32'h0, 1'h0},
      '{1'h0, OFF_REQ, 32'h0, 32'h1, 1'h0},
      '{1'h0, OFF_TIMEOUT, 32'h0, 32'h0, 1'h0},
      '{1'h0, OFF_IRQ_SET, 32'h0, 32'h0, 1'h0},
      '{1'h1, OFF_PAUSE, 32'h9, 32'h0, 1'h0},
      '{1'h0, OFF_PAUSE, 32'h0, 32'h9, 1'h0},
      '{1'h1, OFF_PAUSE, 32'h0, 32'h0, 1'h0},
      '{1'h1, OFF_RELOAD, 32'(RLD), 32'h0, 1'h0},
      '{1'h0, OFF_RELOAD, 32'h0, 32'(RLD), 1'h0},
      '{1'h1, OFF_SLOT_EN, 32'h5, 32'h0, 1'h0},
      '{1'h0, OFF_SLOT_EN, 32'h0, 32'h5, 1'h0},
      '{1'h0, OFF_REQ, 32'h0, 32'h5, 1'h0},
      '{1'h1, 12'h620, 32'h0, 32'h0, 1'h1},
      '{1'h0, 12'h200, 32'h0, 32'h0, 1'h1}
   };
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) lf <= lf + 3'h1;
   // a pulse on any other channel weighs far more than the expected one
   always @(posedge sys_clk) begin
      if (pub != '0) n_pub <= n_pub + ((pub == 256'h8) ? 1 : 16);
   end
   lcw_watchdog i_dut (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_freq_clock(lf[2]), .other_lf_source_running(oth),
      .cpu_sleeping(slp), .debug_halted(hlt), .wake_from_off(wake),
      .link_events(ev), .link_publish(pub), .rc_osc_request(rc), .irq(irq),
      .wdt_reset_req(req)
   );
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task final_report();
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one idle cycle after each transfer, so no signal is set twice at once
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      @(posedge sys_clk);
      while (pready !== 1'h1 && n < 20) begin
         n++;
         @(posedge sys_clk);
      end
      if (n == 20) n_mismatch++;
      q = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic peek(ref logic s, input logic e);
      @(negedge sys_clk);
      chk({31'h0, s}, {31'h0, e});
      @(posedge sys_clk);
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      c = 0;
      while (s !== 1'h1 && c < lim) begin
         c++;
         @(posedge sys_clk);
      end
   endtask
   task pulse(input int k);
      ev <= 256'h1 << k;
      @(posedge sys_clk);
      ev <= '0;
      @(posedge sys_clk);
   endtask
   task do_reset();
      rst <= 1'h1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
   endtask
   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(q, rows[i].e);
         chk({31'h0, er}, {31'h0, rows[i].err});
      end
      slp <= 1'h1;
      hlt <= 1'h1;
      apb(1'h1, OFF_START, 32'h1);
      apb(1'h0, OFF_RUN, 32'h0);
      chk(q, 32'h1);
      apb(1'h1, OFF_RELOAD, 32'h55);
      apb(1'h0, OFF_RELOAD, 32'h0);
      chk(q, 32'(RLD));
      apb(1'h1, OFF_SLOT_BASE, RELOAD_KEY);
      apb(1'h1, OFF_SLOT_BASE + 12'h8, 32'h1);
      apb(1'h1, OFF_SLOT_BASE + 12'h4, RELOAD_KEY);
      apb(1'h0, OFF_REQ, 32'h0);
      chk(q, 32'h4);
      apb(1'h1, OFF_SLOT_BASE + 12'h8, RELOAD_KEY);
      apb(1'h0, OFF_REQ, 32'h0);
      chk(q, 32'h5);
      repeat (10) begin
         apb(1'h1, OFF_SLOT_BASE, RELOAD_KEY);
         apb(1'h1, OFF_SLOT_BASE + 12'h8, RELOAD_KEY);
      end
      peek(req, 1'h0);
      wait_hi(req, 200);
      chk({31'h0, c >= RLD * LFP - 4 && c <= (RLD + 1) * LFP + 8},
         32'h1);
      apb(1'h0, OFF_TIMEOUT, 32'h0);
      chk(q, 32'h1);
      apb(1'h1, OFF_SLOT_BASE, RELOAD_KEY);
      apb(1'h1, OFF_SLOT_BASE + 12'h8, RELOAD_KEY);
      peek(req, 1'h1);
      apb(1'h1, OFF_TIMEOUT, 32'h0);
      apb(1'h0, OFF_TIMEOUT, 32'h0);
      chk(q, 32'h0);
      slp <= 1'h0;
      hlt <= 1'h0;
      do_reset();
      peek(req, 1'h0);
      apb(1'h0, OFF_RELOAD, 32'h0);
      chk(q, 32'hFFFFFFFF);
      apb(1'h1, OFF_RELOAD, 32'(RLD));
      apb(1'h1, OFF_IRQ_SET, 32'h1);
      apb(1'h0, OFF_IRQ_CLR, 32'h0);
      chk(q, 32'h1);
      apb(1'h1, OFF_SUBSCRIBE, 32'h80000005);
      apb(1'h1, OFF_PUBLISH, 32'h80000003);
      pulse(6);
      apb(1'h0, OFF_RUN, 32'h0);
      chk(q, 32'h0);
      pulse(5);
      apb(1'h0, OFF_RUN, 32'h0);
      chk(q, 32'h1);
      wait_hi(irq, 200);
      wait_hi(req, 60);
      chk({31'h0, c >= LFP && c <= 2 * LFP + 4}, 32'h1);
      apb(1'h1, OFF_TIMEOUT, 32'h0);
      peek(irq, 1'h0);
      chk(n_pub, 32'h1);
      apb(1'h1, OFF_IRQ_CLR, 32'h1);
      apb(1'h0, OFF_IRQ_SET, 32'h0);
      chk(q, 32'h0);
      do_reset();
      apb(1'h1, OFF_RELOAD, 32'(RLD));
      apb(1'h1, OFF_PAUSE, 32'h9);
      apb(1'h1, OFF_START, 32'h1);
      peek(rc, 1'h1);
      oth <= 1'h1;
      @(posedge sys_clk);
      peek(rc, 1'h0);
      oth <= 1'h0;
      slp <= 1'h1;
      repeat (150) @(posedge sys_clk);
      slp <= 1'h0;
      hlt <= 1'h1;
      repeat (150) @(posedge sys_clk);
      peek(req, 1'h0);
      hlt <= 1'h0;
      wake <= 1'h1;
      @(posedge sys_clk);
      wake <= 1'h0;
      apb(1'h0, OFF_RUN, 32'h0);
      chk(q, 32'h0);
      apb(1'h1, OFF_RELOAD, 32'h3);
      apb(1'h0, OFF_RELOAD, 32'h0);
      chk(q, 32'h3);
      ce <= 1'h0;
      @(posedge sys_clk);
      peek(pready, 1'h0);
      ce <= 1'h1;
      @(posedge sys_clk);
      final_report();
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
